/* File: common/tlm_defs.vh */
// Shared constants of the loop monitor output block.
// Assumes one 250 MHz clock; included by its bare name.
`ifndef TLM_DEFS_VH
`define TLM_DEFS_VH
// Clock rate in MHz
`define TLM_CLK_MHZ 250
// Output timer resolution, in microseconds (1 ms)
`define TLM_TICK_US 1000
// Milliseconds in one second of cycle setting
`define TLM_MS_PER_S 27'h00003e8
// Remote register word indices
`define TLM_IDX_RISE 5'h03
`define TLM_IDX_ALERT 5'h04
`define TLM_IDX_PV 5'h08
`define TLM_IDX_SV 5'h0c
`define TLM_IDX_MV 5'h10
`define TLM_IDX_MVC 5'h14
// Alert word bit positions
`define TLM_B_OVER 0
`define TLM_B_UNDER 1
`define TLM_B_PA_HH 2
`define TLM_B_PA_LL 3
`define TLM_B_RATE_HI 4
`define TLM_B_RATE_LO 5
`define TLM_B_ALERT1 8
`define TLM_B_LOOP 13
// Full scale divisor for the 5% margin
`define TLM_MARGIN_DIV 18'sh00014
// Control modes
`define TLM_MODE_STD 2'h0
`define TLM_MODE_HC 2'h1
`define TLM_MODE_MIXN 2'h2
`define TLM_MODE_MIXE 2'h3
// Manipulated value limits, tenths of a percent
`define TLM_MV_MIN_STD 16'hffce
`define TLM_MV_MIN_HC 16'h0000
`define TLM_MV_MAX 16'h041a
`define TLM_MV_STOP_STD 16'hffce
`define TLM_MV_STOP_HEAT 16'h0000
`define TLM_MV_STOP_COOL 16'hffce
// Output duty ceiling, 100.0 %
`define TLM_DUTY_MAX 11'h3e8
// Reset value of every monitor word
`define TLM_WORD_RST 16'h0000
`endif

/* File: logic/tlm_monitor.v */
// Monitor words and transistor output timing for four loops.
// Channel inputs come from control logic on CLK_I, so they
// are read without synchronisers; the network side reads a
// word by index and gets it one clock later.
// Summary of operation
// - Rise status valid per control mode
// - Alert bit set while condition detected
// - Bit 0: above measurement range
// - Bit 1: below measurement range
// - Bit 2: at or above upper-upper
// - Bit 3: at or below lower-lower
// - Bits 4,5: rate alarm limits
// - Bits 8-11: configurable alerts 1-4
// - Bit 13 loop break; others zero
// - Temperature input mode: bits 6-15 unused
// - Range is limits widened 5% full scale
// - Range check depends on stop mode
// - Value as is, or times ten
// - Scaled value stored unchanged
// - Out of range value clamped to edge
// - Ramped set value shown continuously
// - Standard value -50..1050, stop -50
// - Heating value 0..1050
// - Heating words first, cooling next
// - Output duty clamped 0..100 percent
// - ON time is cycle times duty
// - Cooling uses its own cycle
`timescale 1ns/100ps
`include "tlm_defs.vh"

module tlm_monitor #(
  // Clocks per 1 ms timer tick
  parameter TICK_CYC = `TLM_TICK_US * `TLM_CLK_MHZ
) (
  input wire CLK_I,
  input wire RST_I,
  // Word index from the network side
  input wire [4:0] RD_ADDR_I,
  // Word read back, one clock after the index
  output wire [15:0] RD_DATA_O,
  // Control mode of the module
  input wire [1:0] CTRL_MODE_I,
  // Temperature input mode
  input wire TEMP_INPUT_MODE_I,
  // Simultaneous rise status from the tuning logic
  input wire [15:0] RISE_STAT_I,
  // Per channel, 16 bits each, channel n at [16n+15:16n]
  input wire [63:0] PV_MEAS_I,
  input wire [63:0] RANGE_LO_I,
  input wire [63:0] RANGE_HI_I,
  input wire [63:0] SCALED_PV_I,
  input wire [63:0] PA_HH_I,
  input wire [63:0] PA_LL_I,
  input wire [63:0] RATE_I,
  input wire [63:0] RATE_HI_I,
  input wire [63:0] RATE_LO_I,
  input wire [63:0] SV_RAMP_I,
  input wire [63:0] MV_I,
  input wire [63:0] MVC_I,
  input wire [63:0] CYCLE_I,
  input wire [63:0] CYCLE_COOL_I,
  // Configurable alerts 1-4, 4 bits per channel
  input wire [15:0] ALERT_I,
  // Per channel flags
  input wire [3:0] LOOP_DISC_I,
  input wire [3:0] DEC_POS_I,
  input wire [3:0] SCALE_EN_I,
  input wire [3:0] STOP_I,
  input wire [3:0] STOP_CHK_I,
  // Transistor outputs, heating or standard
  output wire [3:0] TR_HEAT_O,
  // Transistor outputs, cooling
  output wire [3:0] TR_COOL_O
);

  // Last count of the tick divider; the difference is worked out at
  // full width and then cut to the divider's 24 bits
  localparam [31:0] TICK_LAST_FULL = TICK_CYC - 1;
  localparam [23:0] TICK_LAST = TICK_LAST_FULL[23:0];

  // 5% of full scale of an input range
  function signed [17:0] tlm_margin;
    input signed [15:0] lo;
    input signed [15:0] hi;
    reg signed [17:0] fs;
    begin
      fs = {{2{hi[15]}}, hi} - {{2{lo[15]}}, lo};
      tlm_margin = fs / `TLM_MARGIN_DIV;
    end
  endfunction

  // Stored manipulated value with its storage limits
  function [15:0] tlm_mv_store;
    input signed [15:0] val;
    input stopped;
    input signed [15:0] lo_lim;
    input [15:0] stop_val;
    begin
      if (stopped) begin
        tlm_mv_store = stop_val;
      end else if (val < lo_lim) begin
        tlm_mv_store = lo_lim;
      end else if (val > $signed(`TLM_MV_MAX)) begin
        tlm_mv_store = `TLM_MV_MAX;
      end else begin
        tlm_mv_store = val;
      end
    end
  endfunction

  // Duty actually driven, 0 to 1000 tenths
  function [10:0] tlm_duty;
    input signed [15:0] val;
    begin
      if (val <= $signed(16'h0000)) begin
        tlm_duty = 11'h000;
      end else if (val >= $signed({5'h00, `TLM_DUTY_MAX})) begin
        tlm_duty = `TLM_DUTY_MAX;
      end else begin
        tlm_duty = val[10:0];
      end
    end
  endfunction

  // Monitor words, one per channel
  reg [15:0] alert_r [0:3];
  reg [15:0] pv_r [0:3];
  reg [15:0] sv_r [0:3];
  reg [15:0] mv_r [0:3];
  reg [15:0] mvc_r [0:3];
  // Registered read data
  reg [15:0] rd_data_r;
  // Output timers: 0-3 heating, 4-7 cooling
  reg [26:0] cnt_r [0:7];
  reg [26:0] len_r [0:7];
  reg [26:0] on_r [0:7];
  reg [7:0] tr_r;
  // Millisecond tick divider
  reg [23:0] tick_cnt_r;
  reg tick_r;
  // Mode decodes
  wire hc_mode = (CTRL_MODE_I == `TLM_MODE_HC);
  wire mix_mode = (CTRL_MODE_I == `TLM_MODE_MIXN) ||
                  (CTRL_MODE_I == `TLM_MODE_MIXE);
  // Loop variables
  integer c;
  integer d;
  integer j;
  integer k;
  // Per channel working values
  reg signed [15:0] pv_s;
  reg signed [15:0] lo_s;
  reg signed [15:0] hi_s;
  reg signed [17:0] m_s;
  reg signed [17:0] mlo_s;
  reg signed [17:0] mhi_s;
  reg signed [17:0] pvc_s;
  reg signed [17:0] pv10_s;
  reg over_w;
  reg under_w;
  reg chk_w;
  reg [15:0] alert_w;
  reg [15:0] pv_w;
  // Next values of the monitor words, one per channel
  reg [15:0] alert_nxt [0:3];
  reg [15:0] pv_nxt [0:3];
  reg [15:0] mv_nxt [0:3];
  reg [15:0] mvc_nxt [0:3];

  // Next monitor words, rebuilt from the channel inputs; the
  // working values belong to this process alone
  always @* begin
    for (c = 0; c < 4; c = c + 1) begin
      pv_s = PV_MEAS_I[16*c +: 16];
      lo_s = RANGE_LO_I[16*c +: 16];
      hi_s = RANGE_HI_I[16*c +: 16];
      // Measurement range edges
      m_s = tlm_margin(lo_s, hi_s);
      mlo_s = $signed({{2{lo_s[15]}}, lo_s}) - m_s;
      mhi_s = $signed({{2{hi_s[15]}}, hi_s}) + m_s;
      // A stopped channel is checked only if asked to be
      chk_w = ~STOP_I[c] | STOP_CHK_I[c];
      // A concatenation is unsigned; without the cast a
      // negative value would compare as a huge positive one
      over_w = ($signed({{2{pv_s[15]}}, pv_s}) > mhi_s);
      under_w = ($signed({{2{pv_s[15]}}, pv_s}) < mlo_s);
      // Clamped value; alarms compare it before times ten or scaling
      if (over_w) begin
        pvc_s = mhi_s;
      end else if (under_w) begin
        pvc_s = mlo_s;
      end else begin
        pvc_s = {{2{pv_s[15]}}, pv_s};
      end
      // All bits rebuilt each clock, so they follow the
      // present condition and clear when it goes
      alert_w = 16'h0000;
      alert_w[`TLM_B_OVER] = over_w & chk_w;
      alert_w[`TLM_B_UNDER] = under_w & chk_w;
      alert_w[`TLM_B_PA_HH] =
        (pvc_s >= $signed({{2{PA_HH_I[16*c+15]}},
                           PA_HH_I[16*c +: 16]}));
      alert_w[`TLM_B_PA_LL] =
        (pvc_s <= $signed({{2{PA_LL_I[16*c+15]}},
                           PA_LL_I[16*c +: 16]}));
      alert_w[`TLM_B_RATE_HI] =
        ($signed(RATE_I[16*c +: 16]) >=
         $signed(RATE_HI_I[16*c +: 16]));
      alert_w[`TLM_B_RATE_LO] =
        ($signed(RATE_I[16*c +: 16]) <=
         $signed(RATE_LO_I[16*c +: 16]));
      // Upper bits carry nothing in temperature input mode
      if (!TEMP_INPUT_MODE_I) begin
        alert_w[`TLM_B_ALERT1 +: 4] =
          ALERT_I[4*c +: 4];
        alert_w[`TLM_B_LOOP] = LOOP_DISC_I[c];
      end
      alert_nxt[c] = alert_w;
      // Times ten kept to 18 bits; a result past 16 bits
      // would need a range that the inputs never give
      pv10_s = (pvc_s <<< 3) + (pvc_s <<< 1);
      if (SCALE_EN_I[c]) begin
        pv_w = SCALED_PV_I[16*c +: 16];
      end else if (DEC_POS_I[c]) begin
        pv_w = pv10_s[15:0];
      end else begin
        pv_w = pvc_s[15:0];
      end
      pv_nxt[c] = pv_w;
      // Manipulated values with their storage limits
      if (hc_mode) begin
        mv_nxt[c] = tlm_mv_store(MV_I[16*c +: 16], STOP_I[c],
                                 `TLM_MV_MIN_HC,
                                 `TLM_MV_STOP_HEAT);
        mvc_nxt[c] = tlm_mv_store(MVC_I[16*c +: 16], STOP_I[c],
                                  `TLM_MV_MIN_HC,
                                  `TLM_MV_STOP_COOL);
      end else begin
        mv_nxt[c] = tlm_mv_store(MV_I[16*c +: 16], STOP_I[c],
                                 `TLM_MV_MIN_STD,
                                 `TLM_MV_STOP_STD);
        // No cooling loop outside heating-cooling control
        mvc_nxt[c] = `TLM_WORD_RST;
      end
    end
  end

  // Monitor word registers, loaded every clock
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (d = 0; d < 4; d = d + 1) begin
        alert_r[d] <= `TLM_WORD_RST;
        pv_r[d] <= `TLM_WORD_RST;
        sv_r[d] <= `TLM_WORD_RST;
        mv_r[d] <= `TLM_WORD_RST;
        mvc_r[d] <= `TLM_WORD_RST;
      end
    end else begin
      for (d = 0; d < 4; d = d + 1) begin
        alert_r[d] <= alert_nxt[d];
        pv_r[d] <= pv_nxt[d];
        // Ramped set value taken every clock
        sv_r[d] <= SV_RAMP_I[16*d +: 16];
        mv_r[d] <= mv_nxt[d];
        mvc_r[d] <= mvc_nxt[d];
      end
    end
  end

  // Simultaneous rise area masked by control mode
  reg [15:0] rise_w;
  always @* begin
    if (CTRL_MODE_I == `TLM_MODE_STD) begin
      rise_w = RISE_STAT_I;
    end else if (mix_mode) begin
      rise_w = {RISE_STAT_I[15:8], 8'h00};
    end else begin
      rise_w = 16'h0000;
    end
  end

  // Read mux; unmapped indices and the words that this
  // block does not own read as zero
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_data_r <= `TLM_WORD_RST;
    end else begin
      case (RD_ADDR_I[4:2])
        3'h0: begin
          // Only word 3 of the first group is held here
          if (RD_ADDR_I == `TLM_IDX_RISE) begin
            rd_data_r <= rise_w;
          end else begin
            rd_data_r <= 16'h0000;
          end
        end
        3'h1: begin
          rd_data_r <= alert_r[RD_ADDR_I[1:0]];
        end
        3'h2: begin
          rd_data_r <= pv_r[RD_ADDR_I[1:0]];
        end
        3'h3: begin
          rd_data_r <= sv_r[RD_ADDR_I[1:0]];
        end
        3'h4: begin
          rd_data_r <= mv_r[RD_ADDR_I[1:0]];
        end
        3'h5: begin
          rd_data_r <= mvc_r[RD_ADDR_I[1:0]];
        end
        default: begin
          rd_data_r <= 16'h0000;
        end
      endcase
    end
  end

  assign RD_DATA_O = rd_data_r;

  // Millisecond tick; a divider keeps the single clock
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tick_cnt_r <= 24'h000000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= 24'h000000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 24'h000001;
      tick_r <= 1'b0;
    end
  end

  // Timer working values
  reg [15:0] cyc_w;
  reg [10:0] duty_w;
  // Length and ON time each timer takes at its next boundary
  reg [26:0] len_nxt [0:7];
  reg [26:0] on_nxt [0:7];

  // Next cycle length and ON time per timer, from the stored
  // manipulated values; a cooling timer idles outside mode 1
  always @* begin
    for (j = 0; j < 8; j = j + 1) begin
      if (j < 4) begin
        cyc_w = CYCLE_I[16*j +: 16];
        duty_w = tlm_duty(mv_r[j]);
      end else begin
        cyc_w = CYCLE_COOL_I[16*(j-4) +: 16];
        duty_w = hc_mode ? tlm_duty(mvc_r[j-4]) :
                 11'h000;
      end
      // Cycle in ms, ON time in ms = seconds x tenths
      len_nxt[j] = cyc_w * `TLM_MS_PER_S;
      on_nxt[j] = cyc_w * duty_w;
    end
  end

  // Output timers; length and ON time are taken only at a
  // boundary, so a change mid cycle never cuts a pulse short
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (k = 0; k < 8; k = k + 1) begin
        cnt_r[k] <= 27'h0000000;
        len_r[k] <= 27'h0000000;
        on_r[k] <= 27'h0000000;
      end
      tr_r <= 8'h00;
    end else begin
      for (k = 0; k < 8; k = k + 1) begin
        if (tick_r) begin
          if (cnt_r[k] + 27'h0000001 >= len_r[k]) begin
            cnt_r[k] <= 27'h0000000;
            len_r[k] <= len_nxt[k];
            on_r[k] <= on_nxt[k];
          end else begin
            cnt_r[k] <= cnt_r[k] + 27'h0000001;
          end
        end
        // ON for the front part, OFF for the rest
        tr_r[k] <= (cnt_r[k] < on_r[k]);
      end
    end
  end

  assign TR_HEAT_O = tr_r[3:0];
  assign TR_COOL_O = tr_r[7:4];

endmodule // tlm_monitor

/* File: dv/tlm_monitor_sva.sv */
// Concurrent checks on the loop monitor word port.
// Assumes one clock; read data lags the index by one edge and
// the words lag their inputs by one more edge.
`timescale 1ns/100ps
module tlm_monitor_sva #(
  parameter TICK_CYC = 4 // Clocks per timer tick, handed on by the bind
) (
  input wire CLK_I,
  input wire RST_I,
  input wire [4:0] RD_ADDR_I,
  input wire [15:0] RD_DATA_O,
  input wire [1:0] CTRL_MODE_I,
  input wire TEMP_INPUT_MODE_I,
  input wire [63:0] RATE_I,
  input wire [63:0] RATE_HI_I,
  input wire [63:0] RATE_LO_I,
  input wire [15:0] ALERT_I,
  input wire [3:0] LOOP_DISC_I
);
  // Every check runs on the rising edge and sleeps in reset
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Unused alert positions never carry a one
  a_fixed_zero: assert property (
    RD_ADDR_I[4:2] == 3'h1 |=> {RD_DATA_O[15:14], RD_DATA_O[12], RD_DATA_O[7:6]} == 5'h00)
    else $error("alert word unused bit set");
  // Temperature input mode blanks the upper alert bits
  a_temp_unused: assert property (
    RD_ADDR_I[4:2] == 3'h1 && $past(TEMP_INPUT_MODE_I) |=> RD_DATA_O[15:6] == 10'h000)
    else $error("alert upper bits set in temperature mode");
  // Manipulated value words stay inside the stored span
  a_mv_bounds: assert property (
    RD_ADDR_I[4:2] == 3'h4 |=>
    $signed(RD_DATA_O) >= -16'sd50 && $signed(RD_DATA_O) <= 16'sd1050)
    else $error("manipulated value out of span");
  // Heating words never go negative in heating-cooling mode
  a_heat_floor: assert property (
    RD_ADDR_I[4:2] == 3'h4 && $past(CTRL_MODE_I) == 2'h1 |=> !RD_DATA_O[15])
    else $error("heating value negative");
  // Cooling words exist only in heating-cooling mode
  a_cool_words: assert property (
    RD_ADDR_I[4:2] == 3'h5 && $past(CTRL_MODE_I) != 2'h1 && CTRL_MODE_I != 2'h1
    |=> RD_DATA_O == 16'h0000)
    else $error("cooling word not zero");
  // Rise status of channels 1 and 2 is hidden outside standard mode
  a_rise_mask: assert property (
    RD_ADDR_I == 5'h03 && $past(CTRL_MODE_I) != 2'h0 && CTRL_MODE_I != 2'h0
    |=> RD_DATA_O[7:0] == 8'h00)
    else $error("rise status shown for invalid channel");
  // Channel 2 alerts and loop break follow their inputs two edges on
  a_alert_follow: assert property (
    RD_ADDR_I == 5'h05 && !$past(RST_I) && !$past(TEMP_INPUT_MODE_I) |=>
    RD_DATA_O[11:8] == $past(ALERT_I[7:4], 2) && RD_DATA_O[13] == $past(LOOP_DISC_I[1], 2))
    else $error("alert or loop bit wrong");
  // Channel 2 rate flags compare the variation against both limits
  a_rate_flags: assert property (
    RD_ADDR_I == 5'h05 && !$past(RST_I) |=>
    RD_DATA_O[4] == ($signed($past(RATE_I[31:16], 2)) >= $signed($past(RATE_HI_I[31:16], 2)))
    && RD_DATA_O[5] == ($signed($past(RATE_I[31:16], 2)) <= $signed($past(RATE_LO_I[31:16], 2))))
    else $error("rate flag wrong");
endmodule // tlm_monitor_sva

bind tlm_monitor tlm_monitor_sva #(.TICK_CYC(TICK_CYC)) u_tlm_monitor_sva (
  .CLK_I(CLK_I), .RST_I(RST_I), .RD_ADDR_I(RD_ADDR_I), .RD_DATA_O(RD_DATA_O),
  .CTRL_MODE_I(CTRL_MODE_I), .TEMP_INPUT_MODE_I(TEMP_INPUT_MODE_I), .RATE_I(RATE_I),
  .RATE_HI_I(RATE_HI_I), .RATE_LO_I(RATE_LO_I), .ALERT_I(ALERT_I), .LOOP_DISC_I(LOOP_DISC_I));

/* File: dv/tlm_net_master.sv */
// Network master model: reads monitor words by index.
// Assumes the index is sampled each rising edge, data one edge later.
`timescale 1ns/100ps
module tlm_net_master (
  input wire clk_i,
  input wire [15:0] rd_data_i,
  output logic [4:0] rd_addr_o
);
  // Idle index until the first read
  initial rd_addr_o = 5'h00;
  // Index set off the edge; two edges let the word and read stage settle
  task automatic read_word(input logic [4:0] idx, output logic [15:0] val);
    @(negedge clk_i);
    rd_addr_o = idx;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    val = rd_data_i;
  endtask
endmodule // tlm_net_master

/* File: dv/tb.sv */
// Self-checking bench for the loop monitor block.
// Assumes a 250 MHz clock and a short timer tick parameter.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
  localparam int TICK = 4; // Short tick: one output cycle is 4000 clocks
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [4:0] RD_ADDR_I;
  wire [15:0] RD_DATA_O;
  logic [1:0] CTRL_MODE_I = 2'h0;
  logic TEMP_INPUT_MODE_I = 1'b0;
  logic [15:0] RISE_STAT_I = 16'h7777;
  logic [63:0] PV_MEAS_I = '0, RANGE_LO_I = '0, SCALED_PV_I = '0, RATE_I = '0;
  logic [63:0] RANGE_HI_I = {4{16'h03e8}}, PA_HH_I = {4{16'h01f4}}, PA_LL_I = {4{16'h0064}};
  logic [63:0] RATE_HI_I = {4{16'h0064}}, RATE_LO_I = {4{16'hff9c}}, SV_RAMP_I = '0;
  logic [63:0] MV_I = '0, MVC_I = '0, CYCLE_I = {4{16'h0001}}, CYCLE_COOL_I = {4{16'h0001}};
  logic [15:0] ALERT_I = '0;
  logic [3:0] LOOP_DISC_I = '0, DEC_POS_I = '0, SCALE_EN_I = '0, STOP_I = '0, STOP_CHK_I = '0;
  wire [3:0] TR_HEAT_O, TR_COOL_O;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [15:0] w;
  tlm_monitor #(.TICK_CYC(TICK)) u_tlm_monitor (.CLK_I(CLK_I), .RST_I(RST_I),
    .RD_ADDR_I(RD_ADDR_I), .RD_DATA_O(RD_DATA_O), .CTRL_MODE_I(CTRL_MODE_I),
    .TEMP_INPUT_MODE_I(TEMP_INPUT_MODE_I), .RISE_STAT_I(RISE_STAT_I), .PV_MEAS_I(PV_MEAS_I),
    .RANGE_LO_I(RANGE_LO_I), .RANGE_HI_I(RANGE_HI_I), .SCALED_PV_I(SCALED_PV_I),
    .PA_HH_I(PA_HH_I), .PA_LL_I(PA_LL_I), .RATE_I(RATE_I), .RATE_HI_I(RATE_HI_I),
    .RATE_LO_I(RATE_LO_I), .SV_RAMP_I(SV_RAMP_I), .MV_I(MV_I), .MVC_I(MVC_I),
    .CYCLE_I(CYCLE_I), .CYCLE_COOL_I(CYCLE_COOL_I), .ALERT_I(ALERT_I),
    .LOOP_DISC_I(LOOP_DISC_I), .DEC_POS_I(DEC_POS_I), .SCALE_EN_I(SCALE_EN_I),
    .STOP_I(STOP_I), .STOP_CHK_I(STOP_CHK_I), .TR_HEAT_O(TR_HEAT_O), .TR_COOL_O(TR_COOL_O));
  tlm_net_master u_tlm_net_master (.clk_i(CLK_I), .rd_data_i(RD_DATA_O), .rd_addr_o(RD_ADDR_I));
  // Free-running clock, 4 ns period
  always #2 CLK_I = ~CLK_I;
  // Hang guard: the tests need about 32200 clocks
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 45000) begin
      miscompares++;
      complete_run();
    end
  end
  // One word read and compared
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input string nm);
    u_tlm_net_master.read_word(a, w);
    `CHK(nm, e, w)
  endtask
  task automatic t_rise;
    rd(5'h03, 16'h7777, "rise std");
    @(negedge CLK_I) CTRL_MODE_I = 2'h2;
    rd(5'h03, 16'h7700, "rise mix");
    @(negedge CLK_I) CTRL_MODE_I = 2'h1;
    rd(5'h03, 16'h0000, "rise hc");
    @(negedge CLK_I) CTRL_MODE_I = 2'h0;
    $display("test rise done");
  endtask
  // Channel 2 alert word: range edges, clamped process alarms, rate, stop
  task automatic t_alert;
    logic [15:0] pv [5] = '{16'h041b, 16'h041a, 16'hffcd, 16'h0065, 16'h0064};
    logic [15:0] ex [5] = '{16'h0005, 16'h0004, 16'h000a, 16'h0000, 16'h0008};
    for (int i = 0; i < 5; i++) begin
      @(negedge CLK_I) PV_MEAS_I[31:16] = pv[i];
      rd(5'h05, ex[i], "alert range");
    end
    @(negedge CLK_I);
    PV_MEAS_I[31:16] = 16'h0065;
    RATE_I[31:16] = 16'h0064;
    ALERT_I[7:4] = 4'h9;
    LOOP_DISC_I[1] = 1'b1;
    rd(5'h05, 16'h2910, "alert set");
    @(negedge CLK_I) TEMP_INPUT_MODE_I = 1'b1;
    rd(5'h05, 16'h0010, "alert temp");
    @(negedge CLK_I) RATE_I[31:16] = 16'hff9c;
    rd(5'h05, 16'h0020, "rate low");
    @(negedge CLK_I);
    {TEMP_INPUT_MODE_I, RATE_I[31:16], ALERT_I, LOOP_DISC_I} = '0;
    {PV_MEAS_I[31:16], STOP_I[1]} = {16'h041b, 1'b1};
    rd(5'h05, 16'h0004, "stop masked");
    @(negedge CLK_I) STOP_CHK_I[1] = 1'b1;
    rd(5'h05, 16'h0005, "stop checked");
    @(negedge CLK_I) {STOP_I, STOP_CHK_I} = '0;
    $display("test alert done");
  endtask
  // Channel 3 process value word and channel 4 set value monitor
  task automatic t_pv;
    @(negedge CLK_I) PV_MEAS_I[47:32] = 16'h012c;
    rd(5'h0a, 16'h012c, "pv plain");
    @(negedge CLK_I) DEC_POS_I[2] = 1'b1;
    rd(5'h0a, 16'h0bb8, "pv tenths");
    @(negedge CLK_I) {DEC_POS_I[2], PV_MEAS_I[47:32]} = {1'b0, 16'h07d0};
    rd(5'h0a, 16'h041a, "pv high clamp");
    @(negedge CLK_I) PV_MEAS_I[47:32] = 16'hfed4;
    rd(5'h0a, 16'hffce, "pv low clamp");
    @(negedge CLK_I) {SCALE_EN_I[2], DEC_POS_I[2], SCALED_PV_I[47:32]} = {2'h3, 16'h1234};
    rd(5'h0a, 16'h1234, "pv scaled");
    @(negedge CLK_I) SV_RAMP_I[63:48] = 16'h0456;
    rd(5'h0f, 16'h0456, "sv monitor");
    $display("test pv done");
  endtask
  // Channel 4 heating or standard word and cooling word
  // m packs the control mode over the channel 4 stop flag
  task automatic mv(input logic [2:0] m, input logic [15:0] h, c, eh, ec);
    @(negedge CLK_I) {CTRL_MODE_I, STOP_I[3], MV_I[63:48], MVC_I[63:48]} = {m, h, c};
    rd(5'h13, eh, "mv heat");
    rd(5'h17, ec, "mv cool");
  endtask
  task automatic t_mv;
    mv(3'h0, 16'h07d0, 16'h012c, 16'h041a, 16'h0000);
    mv(3'h0, 16'hff38, 16'h012c, 16'hffce, 16'h0000);
    mv(3'h1, 16'h0258, 16'h012c, 16'hffce, 16'h0000);
    mv(3'h2, 16'hff38, 16'h07d0, 16'h0000, 16'h041a);
    mv(3'h3, 16'h0258, 16'h012c, 16'h0000, 16'hffce);
    $display("test mv done");
  endtask
  // Channel 1 transistor duty counted over one whole output cycle
  task automatic t_out;
    logic [1:0] md [4] = '{2'h0, 2'h0, 2'h1, 2'h1};
    logic [15:0] mh [4] = '{16'h0258, 16'h07d0, 16'hff38, 16'h01f4};
    logic [15:0] mc [4] = '{16'h0000, 16'h0000, 16'h012c, 16'h041a};
    logic [31:0] eh [4] = '{32'h0960, 32'h0fa0, 32'h0000, 32'h07d0};
    logic [31:0] ec [4] = '{32'h0000, 32'h0000, 32'h04b0, 32'h0fa0};
    logic [31:0] nh, nc;
    for (int i = 0; i < 4; i++) begin
      @(negedge CLK_I) {CTRL_MODE_I, STOP_I, MV_I[15:0], MVC_I[15:0]} = {md[i], 4'h0, mh[i], mc[i]};
      repeat (4010) @(negedge CLK_I);
      {nh, nc} = '0;
      repeat (4000) begin
        @(negedge CLK_I);
        nh += TR_HEAT_O[0];
        nc += TR_COOL_O[0];
      end
      `CHK("heat on time", eh[i], nh)
      `CHK("cool on time", ec[i], nc)
    end
    $display("test output done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Reset for two cycles, then the tests in turn
  initial begin
    repeat (2) @(negedge CLK_I);
    RST_I = 1'b0;
    t_rise();
    t_alert();
    t_pv();
    t_mv();
    t_out();
    complete_run();
  end
endmodule // tb
